// *** hw/pbc_clock_generator.sv ***
// loop base clock generator with apb register file
`timescale 1ns/1ps
`default_nettype none
`include "pbc_consts.svh"
module pbc_clock_generator #(
   parameter int CNT_W = 6
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire pbc_pkg::pbc_apb_req_t apb_req,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // crystal pins
   input wire logic oscillator_input_pin,
   output logic oscillator_output_pin,
   // integration unit side
   input wire logic oscillator_enable_in,
   output logic crystal_clock_out,
   output logic base_clock_out,
   output logic clock_unit_irq,
   // analog loop side
   input wire logic vco_clock,
   output logic loop_reference_clock,
   output pbc_pkg::pbc_loop_cfg_t loop_cfg
);
   import pbc_pkg::*;

   if (CNT_W < 5) begin : g_bad_width
      $error("pbc_clock_generator: CNT_W too small");
   end

   localparam int NSYNC = 2;
   localparam int PIN_OSC = 0;
   localparam int PIN_VCO = 1;

   // shared address decode
   function automatic pbc_reg_t pbc_decode(input logic [11:0] addr);
      logic [9:0] idx;
      idx = addr[11:2];
      if (addr[1:0] != 2'h0) begin
         return PBC_REG_NONE;
      end
      unique case (idx)
         `PBC_IDX_CTRL: return PBC_REG_CTRL;
         `PBC_IDX_BW: return PBC_REG_BW;
         `PBC_IDX_MUL: return PBC_REG_MUL;
         `PBC_IDX_ISTAT: return PBC_REG_ISTAT;
         `PBC_IDX_IMASK: return PBC_REG_IMASK;
         default: return PBC_REG_NONE;
      endcase
   endfunction

   // ---------- pin synchronisers ----------
   logic [NSYNC-1:0] pin_raw;
   logic [NSYNC-1:0] sync1_ff;
   logic [NSYNC-1:0] sync2_ff;
   logic [NSYNC-1:0] sync3_ff;

   assign pin_raw[PIN_OSC] = oscillator_input_pin;
   assign pin_raw[PIN_VCO] = vco_clock;

   for (genvar i = 0; i < NSYNC; i++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            sync1_ff[i] <= 1'b0;
            sync2_ff[i] <= 1'b0;
            sync3_ff[i] <= 1'b0;
         end else begin
            sync1_ff[i] <= pin_raw[i];
            sync2_ff[i] <= sync1_ff[i];
            sync3_ff[i] <= sync2_ff[i];
         end
      end
   end

   // ---------- registers ----------
   logic irq_en_ff;
   logic flag_ff;
   logic power_on_ff;
   logic clk_sel_ff;
   logic auto_ff;
   logic acq_ff;
   logic xld_ff;
   logic [7:0] mul_ff;
   logic [1:0] istat_ff;
   logic [1:0] imask_ff;
   logic [31:0] prdata_ff;

   pbc_reg_t sel;
   logic wr;
   logic rd;
   logic setup_rd;
   logic [7:0] wbyte;

   assign sel = pbc_decode(apb_req.paddr);
   assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite && (sel != PBC_REG_NONE);
   assign rd = apb_req.psel && apb_req.penable && !apb_req.pwrite;
   assign setup_rd = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
   assign wbyte = apb_req.pwdata[7:0];

   // ---------- crystal path ----------
   logic osc_run;
   logic xtal_ff;
   logic ref_ff;
   logic osc_drive_ff;
   logic xtal_rise;

   assign osc_run = oscillator_enable_in;

   // crystal clock and its reference copy
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xtal_ff <= 1'b0;
         ref_ff <= 1'b0;
         osc_drive_ff <= 1'b0;
      end else begin
         xtal_ff <= osc_run && sync2_ff[PIN_OSC];
         ref_ff <= osc_run && sync2_ff[PIN_OSC];
         osc_drive_ff <= osc_run && !sync2_ff[PIN_OSC];
      end
   end

   assign xtal_rise = osc_run && sync2_ff[PIN_OSC] && !sync3_ff[PIN_OSC];

   // crystal clock out does not depend on the select
   assign crystal_clock_out = xtal_ff;
   assign loop_reference_clock = ref_ff;
   assign oscillator_output_pin = osc_drive_ff;

   // ---------- loop and lock detector ----------
   logic vco_rise;
   logic det_locked;
   logic det_track;
   logic lock_ind;
   logic lock_prev_ff;
   logic lock_toggle;

   assign vco_rise = power_on_ff && sync2_ff[PIN_VCO] && !sync3_ff[PIN_VCO];

   // detector runs the filter mode only in auto mode
   pbc_lock_detector #(
      .CNT_W(CNT_W)
   ) u_lock_detector (
      .pclk(pclk),
      .presetn(presetn),
      .enable(power_on_ff && auto_ff && osc_run),
      .ref_rise(xtal_rise),
      .vco_rise(vco_rise),
      .multiplier(mul_ff[7:4]),
      .locked(det_locked),
      .tracking(det_track)
   );

   // lock indicator off in manual mode
   assign lock_ind = auto_ff && det_locked;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_prev_ff <= 1'b0;
      end else begin
         lock_prev_ff <= lock_ind;
      end
   end

   assign lock_toggle = auto_ff && (lock_ind != lock_prev_ff);

   // programmed multiple and range to the analog loop
   assign loop_cfg.power_on = power_on_ff;
   assign loop_cfg.track = auto_ff ? det_track : acq_ff;
   assign loop_cfg.crystal_loss_detect = xld_ff;
   assign loop_cfg.multiplier_bits = mul_ff[7:4];
   assign loop_cfg.vco_range_bits = mul_ff[3:0];

   // ---------- base clock ----------
   logic base_ff;
   logic src_rise;

   // select 1 takes vco, 0 takes crystal
   assign src_rise = clk_sel_ff ? vco_rise : xtal_rise;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         base_ff <= 1'b0;
      end else if (src_rise) begin
         base_ff <= !base_ff;
      end
   end

   assign base_clock_out = base_ff;

   // ---------- control register ----------
   // flag and low bits ignore writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_en_ff <= 1'b0;
         power_on_ff <= 1'b0;
         clk_sel_ff <= 1'b0;
      end else if (wr && (sel == PBC_REG_CTRL)) begin
         irq_en_ff <= wbyte[`PBC_CTRL_IE];
         power_on_ff <= wbyte[`PBC_CTRL_ON];
         clk_sel_ff <= wbyte[`PBC_CTRL_SEL];
      end
   end

   // set on toggle, cleared by control read; set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_ff <= 1'b0;
      end else if (lock_toggle) begin
         flag_ff <= 1'b1;
      end else if (rd && (sel == PBC_REG_CTRL) && prdata_ff[`PBC_CTRL_FLAG]) begin
         flag_ff <= 1'b0;
      end
   end

   // ---------- bandwidth and multiplier ----------
   // auto, acq, loss detect writable; lock is not
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         auto_ff <= 1'b0;
         xld_ff <= 1'b0;
      end else if (wr && (sel == PBC_REG_BW)) begin
         auto_ff <= wbyte[`PBC_BW_AUTO];
         xld_ff <= wbyte[`PBC_BW_XLD];
      end
   end

   // acq writable only in manual mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acq_ff <= 1'b0;
      end else if (wr && (sel == PBC_REG_BW) && !auto_ff) begin
         acq_ff <= wbyte[`PBC_BW_ACQ];
      end
   end

   // all eight bits read and write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mul_ff <= `PBC_MUL_RESET;
      end else if (wr && (sel == PBC_REG_MUL)) begin
         mul_ff <= wbyte;
      end
   end

   // ---------- interrupt status and mask ----------
   logic [1:0] irq_set;
   logic [1:0] irq_clr;

   // separate events for gaining and losing lock
   // only while the enable bit is set
   assign irq_set[`PBC_IRQ_GAIN] = irq_en_ff && lock_toggle && lock_ind;
   assign irq_set[`PBC_IRQ_LOSS] = irq_en_ff && lock_toggle && !lock_ind;
   assign irq_clr = (wr && (sel == PBC_REG_ISTAT)) ? wbyte[1:0] : 2'h0;

   // write-one-to-clear, a new event beats the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         istat_ff <= 2'h0;
      end else begin
         istat_ff <= irq_set | (istat_ff & ~irq_clr);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         imask_ff <= 2'h0;
      end else if (wr && (sel == PBC_REG_IMASK)) begin
         imask_ff <= wbyte[1:0];
      end
   end

   // nothing leaves the block in manual mode
   assign clock_unit_irq = auto_ff && |(istat_ff & imask_ff);

   // ---------- read path ----------
   logic [7:0] rbyte;

   always_comb begin
      rbyte = 8'h00;
      unique case (sel)
         PBC_REG_CTRL: begin
            rbyte = {irq_en_ff, flag_ff, power_on_ff, clk_sel_ff, `PBC_CTRL_LOW_ONES};
         end
         PBC_REG_BW: begin
            rbyte = {auto_ff, lock_ind, loop_cfg.track, xld_ff, `PBC_BW_LOW_ZERO};
         end
         PBC_REG_MUL: begin
            rbyte = mul_ff;
         end
         PBC_REG_ISTAT: begin
            rbyte = {6'h00, istat_ff};
         end
         PBC_REG_IMASK: begin
            rbyte = {6'h00, imask_ff};
         end
         PBC_REG_NONE: begin
            rbyte = 8'h00;
         end
      endcase
   end

   // data captured in setup so it is a flop by the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h0;
      end else if (setup_rd) begin
         prdata_ff <= {24'h000000, rbyte};
      end
   end

   assign prdata = prdata_ff;
   assign pready = 1'b1;
   assign pslverr = apb_req.psel && apb_req.penable && (sel == PBC_REG_NONE);
endmodule
`default_nettype wire

// *** hw/pbc_consts.svh ***
// constants for the loop base clock generator
// Functional notes
// - Base clock comes from the halved crystal clock or the halved vco clock, chosen by software.
// - The crystal oscillator runs only while the integration unit asserts its enable.
// - Crystal clock out follows the crystal, and a buffered copy is the loop reference.
// - The loop vco runs at a programmable integer multiple of the reference.
// - An interrupt is raised both on entering and on leaving lock.
// - Control holds irq enable, irq flag, power on, clock select in bits 7..4; flag and 3..0 ignore writes, 3..0 read as 1.
// - Bandwidth holds auto, read-only lock, acq and crystal loss detect in bits 7..4; 3..0 read 0.
// - Multiplier register holds four multiplier bits and four range bits, all read/write.
// - Crystal clock out is available regardless of the base clock selection.
// - Select 1 takes the halved vco clock, select 0 the halved crystal clock.
// - In auto mode the lock detector drives acq/track itself and acq is read-only.
// - Lock toggles interrupt only while the irq enable bit is 1.
// - In manual mode the lock indicator is off and no interrupt leaves the block.
`ifndef PBC_CONSTS_SVH
`define PBC_CONSTS_SVH
// register indices; byte address is four times the index
`define PBC_IDX_CTRL 10'h01c
`define PBC_IDX_BW 10'h01d
`define PBC_IDX_MUL 10'h01e
`define PBC_IDX_ISTAT 10'h01f
`define PBC_IDX_IMASK 10'h020
// field positions
`define PBC_CTRL_IE 7
`define PBC_CTRL_FLAG 6
`define PBC_CTRL_ON 5
`define PBC_CTRL_SEL 4
`define PBC_BW_AUTO 7
`define PBC_BW_LOCK 6
`define PBC_BW_ACQ 5
`define PBC_BW_XLD 4
`define PBC_IRQ_GAIN 0
`define PBC_IRQ_LOSS 1
// fixed read values, resets and lock detector match counts
`define PBC_CTRL_LOW_ONES 4'hf
`define PBC_BW_LOW_ZERO 4'h0
`define PBC_MUL_RESET 8'h10
`define PBC_TRK_MATCHES 3'h2
`define PBC_LOCK_MATCHES 3'h4
`endif

// *** hw/pbc_pkg.sv ***
// types shared by the loop base clock generator
package pbc_pkg;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } pbc_apb_req_t;
   typedef struct packed {
      logic power_on;
      logic track;
      logic crystal_loss_detect;
      logic [3:0] multiplier_bits;
      logic [3:0] vco_range_bits;
   } pbc_loop_cfg_t;
   typedef enum logic [2:0] {
      PBC_REG_CTRL,
      PBC_REG_BW,
      PBC_REG_MUL,
      PBC_REG_ISTAT,
      PBC_REG_IMASK,
      PBC_REG_NONE
   } pbc_reg_t;
   typedef enum logic [1:0] {
      PBC_LD_OFF,
      PBC_LD_ACQUIRE,
      PBC_LD_TRACK,
      PBC_LD_LOCKED
   } pbc_ld_state_t;
endpackage

// *** hw/pbc_lock_detector.sv ***
// lock detector: counts vco edges per reference period
`timescale 1ns/1ps
`default_nettype none
`include "pbc_consts.svh"
module pbc_lock_detector #(
   parameter int CNT_W = 6
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // edges and control
   input wire logic enable,
   input wire logic ref_rise,
   input wire logic vco_rise,
   input wire logic [3:0] multiplier,
   // state
   output logic locked,
   output logic tracking
);
   import pbc_pkg::*;

   if (CNT_W < 5) begin : g_bad_width
      $error("pbc_lock_detector: CNT_W must hold the largest multiplier");
   end

   pbc_ld_state_t state_ff;
   pbc_ld_state_t nxt_state;
   logic [CNT_W-1:0] vco_cnt_ff;
   logic [2:0] streak_ff;
   logic match;

   assign match = (vco_cnt_ff == CNT_W'(multiplier));

   // count saturates so a runaway vco never aliases to a match
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vco_cnt_ff <= '0;
      end else if (!enable || ref_rise) begin
         vco_cnt_ff <= CNT_W'(vco_rise);
      end else if (vco_rise && (vco_cnt_ff != '1)) begin
         vco_cnt_ff <= vco_cnt_ff + CNT_W'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         streak_ff <= '0;
      end else if (!enable || (ref_rise && !match)) begin
         streak_ff <= '0;
      end else if (ref_rise && (streak_ff != 3'h7)) begin
         streak_ff <= streak_ff + 3'h1;
      end
   end

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         PBC_LD_OFF: begin
            nxt_state = PBC_LD_ACQUIRE;
         end
         PBC_LD_ACQUIRE: begin
            if (ref_rise && match && (streak_ff + 3'h1 >= `PBC_TRK_MATCHES)) begin
               nxt_state = PBC_LD_TRACK;
            end
         end
         PBC_LD_TRACK: begin
            if (ref_rise && !match) begin
               nxt_state = PBC_LD_ACQUIRE;
            end else if (ref_rise && (streak_ff + 3'h1 >= `PBC_LOCK_MATCHES)) begin
               nxt_state = PBC_LD_LOCKED;
            end
         end
         PBC_LD_LOCKED: begin
            // one bad period drops lock but keeps the narrow filter
            if (ref_rise && !match) begin
               nxt_state = PBC_LD_TRACK;
            end
         end
      endcase
      if (!enable) begin
         nxt_state = PBC_LD_OFF;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= PBC_LD_OFF;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign locked = (state_ff == PBC_LD_LOCKED);
   assign tracking = (state_ff == PBC_LD_TRACK) || (state_ff == PBC_LD_LOCKED);
endmodule
`default_nettype wire

// *** sim/pbc_clock_generator_sva.sv ***
// port assertions for the clock generator
`timescale 1ns/1ps
`default_nettype none
module pbc_clock_generator_sva #(
   parameter int CNT_W = 6
) (
   // clock, reset, bus
   input wire logic pclk,
   input wire logic presetn,
   input wire pbc_pkg::pbc_apb_req_t apb_req,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // clocks and loop
   input wire logic oscillator_input_pin,
   input wire logic oscillator_output_pin,
   input wire logic oscillator_enable_in,
   input wire logic crystal_clock_out,
   input wire logic base_clock_out,
   input wire logic clock_unit_irq,
   input wire logic vco_clock,
   input wire logic loop_reference_clock,
   input wire pbc_pkg::pbc_loop_cfg_t loop_cfg
);
   import pbc_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire acc = apb_req.psel && apb_req.penable;
   wire rd_acc = acc && !apb_req.pwrite;
   wire wr_acc = acc && apb_req.pwrite;
   // enable must be steady so the gate is not the cause
   sequence xtal_rise_s;
      oscillator_enable_in [*5] ##0 $rose(oscillator_input_pin);
   endsequence
   ref_copy_a: assert property (loop_reference_clock == crystal_clock_out)
      else $error("reference clock differs from crystal clock");
   osc_gate_a: assert property (!oscillator_enable_in [*2] |->
      !crystal_clock_out && !oscillator_output_pin) else $error("oscillator runs while disabled");
   xtal_follow_a: assert property (xtal_rise_s |->
      ##[1:4] (crystal_clock_out || !oscillator_enable_in)) else $error("crystal clock not following");
   ctrl_ones_a: assert property (rd_acc && apb_req.paddr == 12'h070 |->
      prdata[3:0] == 4'hf && prdata[31:8] == 24'h0) else $error("control low bits wrong");
   bw_zero_a: assert property (rd_acc && apb_req.paddr == 12'h074 |->
      prdata[3:0] == 4'h0 && prdata[31:8] == 24'h0) else $error("bandwidth low bits wrong");
   mul_read_a: assert property (rd_acc && apb_req.paddr == 12'h078 |->
      prdata[7:0] == {loop_cfg.multiplier_bits, loop_cfg.vco_range_bits})
      else $error("multiplier read differs from loop settings");
   mul_write_a: assert property (wr_acc && apb_req.paddr == 12'h078 |=>
      {loop_cfg.multiplier_bits, loop_cfg.vco_range_bits} == $past(apb_req.pwdata[7:0]))
      else $error("multiplier write not applied");
   power_on_a: assert property (wr_acc && apb_req.paddr == 12'h070 |=>
      loop_cfg.power_on == $past(apb_req.pwdata[5])) else $error("power on bit not applied");
endmodule
bind pbc_clock_generator pbc_clock_generator_sva #(.CNT_W(CNT_W)) sva_u (.pclk(pclk),
   .presetn(presetn), .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .oscillator_input_pin(oscillator_input_pin), .oscillator_output_pin(oscillator_output_pin),
   .oscillator_enable_in(oscillator_enable_in), .crystal_clock_out(crystal_clock_out),
   .base_clock_out(base_clock_out), .clock_unit_irq(clock_unit_irq), .vco_clock(vco_clock),
   .loop_reference_clock(loop_reference_clock), .loop_cfg(loop_cfg));
`default_nettype wire

// *** sim/pbc_xtal_vco_model.sv ***
// crystal source and analog vco stand-in
`timescale 1ns/1ps
`default_nettype none
module pbc_xtal_vco_model (
   // loop settings
   input wire logic run_vco,
   input wire logic [3:0] mult,
   input wire logic wrong,
   // clocks
   output logic xtal,
   output logic vco
);
   real per;
   int n;
   initial begin
      xtal = 1'b0;
      forever begin
         #440 xtal = 1'b1;
         #200 xtal = 1'b0;
      end
   end
   initial begin
      vco = 1'b0;
      forever begin
         @(posedge xtal);
         n = wrong ? int'(mult) + 1 : int'(mult);
         // n rising edges per reference period; short of 640 to catch the next edge
         if (run_vco && n > 0) begin
            per = 600.0 / n;
            repeat (n) begin
               #(per / 4) vco = 1'b1;
               #(per / 2) vco = 1'b0;
               #(per / 4);
            end
         end
      end
   end
endmodule
`default_nettype wire

// *** sim/pbc_clock_generator_tb.sv ***
// self-checking bench for the clock generator
`timescale 1ns/1ps
`default_nettype none
module pbc_clock_generator_tb;
   import pbc_pkg::*;
   localparam logic [11:0] A_CTL = 12'h070, A_BW = 12'h074, A_MUL = 12'h078;
   localparam logic [11:0] A_IST = 12'h07c, A_IMK = 12'h080;
   logic pclk, presetn, osc_en, xtal, vco, wrong, err;
   logic pready, pslverr, osc_out, xclk, bclk, irq, rclk;
   logic [31:0] prdata, rd;
   pbc_apb_req_t req;
   pbc_loop_cfg_t cfg;
   int failures = 0, checks_done = 0, cycles = 0, n;
   pbc_clock_generator #(.CNT_W(6)) dut_u (.pclk(pclk), .presetn(presetn), .apb_req(req),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .oscillator_input_pin(xtal),
      .oscillator_output_pin(osc_out), .oscillator_enable_in(osc_en), .crystal_clock_out(xclk),
      .base_clock_out(bclk), .clock_unit_irq(irq), .vco_clock(vco),
      .loop_reference_clock(rclk), .loop_cfg(cfg));
   pbc_xtal_vco_model far_u (.run_vco(cfg.power_on), .mult(cfg.multiplier_bits),
      .wrong(wrong), .xtal(xtal), .vco(vco));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task automatic tally_and_finish;
      if (failures == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 40000) begin
         failures++;
         tally_and_finish;
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge pclk);
      req.penable <= 1'b1;
      // no fixed wait count; only the bench timeout ends a stalled access
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      req <= '0;
   endtask
   task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask
   task automatic wait_irq(input logic lvl);
      for (int i = 0; i < 3000 && irq !== lvl; i++) @(posedge pclk);
      chk("irq", {31'h0, lvl}, {31'h0, irq});
   endtask
   // base clock changes across per crystal periods
   task automatic count_base(input int per);
      int r;
      logic pc, pb;
      r = 0;
      n = 0;
      pc = xclk;
      pb = bclk;
      for (int i = 0; i < per * 70 + 200 && r <= per; i++) begin
         @(posedge pclk);
         if (xclk && !pc) r++;
         if (r >= 1 && r <= per && bclk !== pb) n++;
         pc = xclk;
         pb = bclk;
      end
   endtask
   initial begin
      presetn = 1'b0;
      req = '0;
      osc_en = 1'b1;
      wrong = 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rchk("ctrl", A_CTL, 32'h0f);
      rchk("bw", A_BW, 32'h00);
      rchk("mul", A_MUL, 32'h10);
      rchk("unmapped", 12'h084, 32'h0);
      chk("slverr", 32'h1, {31'h0, err});
      rchk("misaligned", 12'h071, 32'h0);
      chk("slverr", 32'h1, {31'h0, err});
      apb(1'b1, A_CTL, 32'hcf);
      rchk("ctrl", A_CTL, 32'h8f);
      apb(1'b1, A_BW, 32'h7f);
      rchk("bw", A_BW, 32'h30);
      apb(1'b1, A_MUL, 32'h4a);
      rchk("mul", A_MUL, 32'h4a);
      chk("cfg", 32'h34a, {22'h0, cfg.track, cfg.crystal_loss_detect, cfg[7:0]});
      apb(1'b1, A_BW, 32'h00);
      count_base(8);
      chk("crystal base", 32'd8, n);
      osc_en <= 1'b0;
      count_base(2);
      chk("stopped base", 32'd0, n);
      osc_en <= 1'b1;
      apb(1'b1, A_IMK, 32'h3);
      apb(1'b1, A_BW, 32'h80);
      apb(1'b1, A_CTL, 32'ha0);
      wait_irq(1'b1);
      rchk("istat", A_IST, 32'h1);
      rchk("ctrl", A_CTL, 32'hef);
      rchk("ctrl", A_CTL, 32'haf);
      rchk("bw", A_BW, 32'he0);
      apb(1'b1, A_IST, 32'h1);
      wait_irq(1'b0);
      apb(1'b1, A_CTL, 32'hb0);
      count_base(8);
      chk("vco base", 32'd32, n);
      wrong <= 1'b1;
      wait_irq(1'b1);
      rchk("istat", A_IST, 32'h2);
      apb(1'b0, A_BW, 32'h0);
      chk("bw lock", 32'h80, rd & 32'hc0);
      apb(1'b1, A_IST, 32'h2);
      apb(1'b1, A_IMK, 32'h0);
      wrong <= 1'b0;
      rd = '0;
      for (int i = 0; i < 500 && rd[6] !== 1'b1; i++) apb(1'b0, A_BW, 32'h0);
      chk("masked irq", 32'h0, {31'h0, irq});
      rchk("istat", A_IST, 32'h1);
      apb(1'b1, A_IMK, 32'h1);
      wait_irq(1'b1);
      apb(1'b1, A_BW, 32'h00);
      wait_irq(1'b0);
      rchk("bw", A_BW, 32'h00);
      // irq enable off: a new lock sets the flag but no status bit
      apb(1'b1, A_IST, 32'h3);
      apb(1'b1, A_CTL, 32'h20);
      rchk("ctrl", A_CTL, 32'h6f);
      apb(1'b1, A_BW, 32'h80);
      rd = '0;
      for (int i = 0; i < 500 && rd[6] !== 1'b1; i++) apb(1'b0, A_BW, 32'h0);
      chk("disabled irq", 32'h0, {31'h0, irq});
      rchk("istat", A_IST, 32'h0);
      rchk("ctrl", A_CTL, 32'h6f);
      tally_and_finish;
   end
endmodule
`default_nettype wire
